// ---- shared/dfa_pkg.sv ----
package dfa_pkg;

  // Register offsets on the local microcontroller port.
  localparam logic [7:0] DFA_AUX0_OFFSET = 8'h48;
  localparam logic [7:0] DFA_AUX1_OFFSET = 8'h4F;
  localparam logic [7:0] DFA_BUF_DATA_OFFSET = 8'h70;
  localparam logic [7:0] DFA_FMT_CTRL_OFFSET = 8'h71;
  localparam logic [7:0] DFA_HOST_ACK_OFFSET = 8'h73;
  localparam logic [7:0] DFA_BRANCH_OFFSET = 8'h78;
  localparam logic [7:0] DFA_FMT_STAT_OFFSET = 8'h79;

  // Field positions of auxiliary control register 0.
  localparam int DFA_A0_AUTOINC = 0;
  localparam int DFA_A0_PWRDN = 1;
  localparam int DFA_A0_ECCERR = 2;
  localparam int DFA_A0_TWOIDX = 3;
  localparam int DFA_A0_CLRDMA = 4;
  localparam int DFA_A0_BRSRC = 5;
  localparam int DFA_A0_TIDXEN = 6;
  localparam int DFA_A0_SPLIT = 7;

  // Field positions of auxiliary control register 1.
  localparam int DFA_A1_BUSYCLR = 3;
  localparam int DFA_A1_FILTDIS = 4;
  localparam int DFA_A1_ECCPRE = 5;
  localparam int DFA_A1_WAIT_LO = 6;

  // Formatter reset bit in register 71H.
  localparam int DFA_FMT_RESET_BIT = 5;
  // Count field bit that arms the two-index detector.
  localparam int DFA_CNT_ARM_BIT = 5;

  // Values after local reset.
  localparam logic [7:0] DFA_AUX0_RESET = 8'h00;
  localparam logic [1:0] DFA_WAIT_RESET = 2'h3;

  // Filter glitch width and derived cycle count at 125 MHz.
  localparam int DFA_CLK_MHZ = 125;
  localparam int DFA_GLITCH_NS = 10;
  localparam int DFA_GLITCH_CYC = (DFA_GLITCH_NS * DFA_CLK_MHZ + 999) / 1000;

  // Microcontroller register access.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dfa_bus_t;

  // Sequencer word fields that the block observes.
  typedef struct packed {
    logic read_gate;
    logic xfer;
    logic [7:0] count;
    logic [7:0] data;
    logic ctrl_bit3;
  } dfa_seq_t;

  // Wait-state machine states, Gray coded.
  typedef enum logic [1:0] {
    DFA_W_IDLE = 2'b00,
    DFA_W_COUNT = 2'b01,
    DFA_W_READY = 2'b11
  } dfa_wstate_t;

endpackage : dfa_pkg

// ---- design/dfa_glitch_filter.sv ----
`timescale 1ns/1ps
module dfa_glitch_filter
  import dfa_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic bypass_i, // Filter disable control.
  input wire logic sig_i, // Raw read/reference clock level.
  output logic sig_o // Filtered level.
);
  import dfa_pkg::*;

  // All state in one struct.
  typedef struct packed {
    logic out;
    logic [3:0] cnt;
  } dfa_flt_st_t;

  dfa_flt_st_t st_reg; // Registered state.
  dfa_flt_st_t st_next; // Next state.

  // A level must persist past the glitch width before it is passed on.
  always_comb begin
    st_next = st_reg;
    if (sig_i == st_reg.out) begin
      st_next.cnt = 4'h0;
    end else if (st_reg.cnt >= 4'(DFA_GLITCH_CYC)) begin
      st_next.out = sig_i;
      st_next.cnt = 4'h0;
    end else begin
      st_next.cnt = st_reg.cnt + 4'h1;
    end
  end

  // Registers the filter state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Bypass passes the input directly for high data rates.
  assign sig_o = bypass_i ? sig_i : st_reg.out;

endmodule : dfa_glitch_filter

// ---- design/dfa_wait_gen.sv ----
`timescale 1ns/1ps
module dfa_wait_gen
  import dfa_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic access_i, // Level high while an access is in progress.
  input wire logic [1:0] wait_sel_i, // Selected wait states.
  input wire logic buf_tick_i, // Buffer timing clock edge pulse.
  output logic ready_n_o // Local ready, active low.
);
  import dfa_pkg::*;

  // All state in one struct.
  typedef struct packed {
    dfa_wstate_t st;
    logic [1:0] left;
  } dfa_wg_st_t;

  dfa_wg_st_t st_reg; // Registered state.
  dfa_wg_st_t st_next; // Next state.

  // Counts buffer timing ticks; the unsynchronised first tick yields n..n+1.
  always_comb begin
    st_next = st_reg;
    unique case (st_reg.st)
      DFA_W_IDLE: begin
        if (access_i) begin
          st_next.left = wait_sel_i;
          st_next.st = (wait_sel_i == 2'h0) ? DFA_W_READY : DFA_W_COUNT;
        end
      end
      DFA_W_COUNT: begin
        if (!access_i) begin
          st_next.st = DFA_W_IDLE;
        end else if (buf_tick_i) begin
          st_next.left = st_reg.left - 2'h1;
          if (st_reg.left == 2'h1) begin
            st_next.st = DFA_W_READY;
          end
        end
      end
      DFA_W_READY: begin
        if (!access_i) begin
          st_next.st = DFA_W_IDLE;
        end
      end
      default: begin
        st_next.st = DFA_W_IDLE;
      end
    endcase
  end

  // Registers the wait state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Ready is low once the wait has elapsed.
  assign ready_n_o = !(access_i && (st_reg.st == DFA_W_READY || (st_reg.st == DFA_W_IDLE && wait_sel_i == 2'h0)));

endmodule : dfa_wait_gen

// ---- design/dfa_aux_control.sv ----
`timescale 1ns/1ps
// Contract
// - Auto-increment advances write or read pointer.
// - Power-down gates off unused clocking.
// - Power-down clears on resets and commands.
// - ECC error status sets on error.
// - ECC status clears on reset, start, write.
// - Two-index status sets after two edges.
// - Clear-DMA pulse clears host DMA enable.
// - Branch source selects data field or 78H.
// - Detector arms on matching sequencer word.
// - Detector stays armed until disarm event.
// - Two-index status stops the sequencer.
// - Split enable selects control bit meaning.
// - XT busy clears on completion status read.
// - AT busy clears on final read sector.
// - Filter disable bypasses clock glitch filter.
// - ECC preset zeros when set, ones otherwise.
// - Wait field delays local ready.
// - Local reset forces wait field to 11.
// - Wait period is buffer timing clock.
// - Local reset clears control registers.
// - Sequencer words written only when stopped.
module dfa_aux_control
  import dfa_pkg::*;
(
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Local reset, synchronous, active high.
  input wire logic host_bus_reset_i, // Host bus reset level.
  input wire logic host_prog_reset_i, // Host programmed reset pulse.
  input wire logic host_cmd_i, // Host issued a command, pulse.
  input dfa_pkg::dfa_bus_t bus_i, // Microcontroller register access.
  output logic [7:0] rdata_o, // Read data of the addressed register.
  output logic local_ready_n_o, // Local ready, active low.
  input wire logic buffer_timing_clock_i, // Buffer timing clock tick pulse.
  input wire logic read_op_select_i, // Pointer select for auto-increment.
  output logic write_address_pointer_inc_o, // Advance write pointer, pulse.
  output logic read_address_pointer_inc_o, // Advance read pointer, pulse.
  output logic clock_run_o, // Enable for gated unused clocking.
  input wire logic ecc_error_i, // ECC error detected, pulse.
  input wire logic ecc_start_i, // New ECC calculation starts, pulse.
  input wire logic id_field_i, // Error lies in ID field (7DH bit 4).
  output logic ecc_preset_ones_o, // ECC generator preset value.
  input wire logic index_edge_i, // Index edge, pulse.
  input wire logic fmt_buf_xfer_i, // Formatter to buffer transfer, pulse.
  input wire logic seq_exec_i, // New sequencer word executing, pulse.
  input wire logic seq_stopped_i, // Sequencer in stopped state.
  input dfa_pkg::dfa_seq_t seq_i, // Current sequencer word fields.
  input wire logic [7:0] branch_reg_i, // Contents of register 78H.
  output logic [4:0] branch_addr_o, // Sequencer branch address.
  output logic force_stop_o, // Internal stopped condition.
  output logic split_field_o, // Split data field indicator.
  output logic invalid_nrz_block_o, // Invalid NRZ suppression control.
  output logic seq_write_ok_o, // Sequencer word writes allowed.
  output logic clear_dma_enable_o, // Clear host DMA enable bit.
  input wire logic xt_mode_i, // XT mode selected.
  input wire logic status_read_i, // Host read completion status, pulse.
  input wire logic last_read_sector_i, // Final sector of a read command.
  input wire logic fifo_full_i, // Host FIFO filled.
  input wire logic dma_req_i, // Host DMA request asserted.
  output logic busy_clear_o, // Clear busy bit in 55H, pulse.
  input wire logic media_read_enable_i, // Read gate level.
  input wire logic rd_ref_clk_i, // Raw read/reference clock.
  output logic rd_ref_clk_o // Filtered read/reference clock.
);
  import dfa_pkg::*;

  // All block state in one struct.
  typedef struct packed {
    logic [7:0] aux0; // Auxiliary control register 0.
    logic [7:0] aux1; // Auxiliary control register 1.
    logic armed; // Two-index detector armed.
    logic [1:0] idx_cnt; // Index edges seen while armed.
    logic pd_lock; // Power-down set blocked after a host command.
    logic wp_inc; // Write pointer advance pulse.
    logic rp_inc; // Read pointer advance pulse.
    logic dma_clr; // DMA enable clear pulse.
    logic busy_clr; // Busy clear pulse.
    logic ecc_id; // Field type of the latched ECC error.
  } dfa_state_t;

  dfa_state_t st_reg; // Registered state.
  dfa_state_t st_next; // Next state.

  // Decodes a write strobe to one register offset.
  function automatic logic wr_hit(input dfa_bus_t b, input logic [7:0] off);
    wr_hit = b.wr && (b.addr == off);
  endfunction : wr_hit

  logic hard_clear; // Host or programmed reset, clears the shared controls.
  logic filt_out; // Filtered clock from the filter.
  logic access; // Register access in progress.

  assign hard_clear = host_bus_reset_i || host_prog_reset_i;
  assign access = bus_i.rd || bus_i.wr;

  // Computes the next state of the registers and detector.
  always_comb begin
    st_next = st_reg;
    st_next.wp_inc = 1'b0;
    st_next.rp_inc = 1'b0;
    st_next.busy_clr = 1'b0;
    // Software writes to register 0; status bits keep their own value.
    if (wr_hit(bus_i, DFA_AUX0_OFFSET)) begin
      st_next.aux0[DFA_A0_AUTOINC] = bus_i.wdata[DFA_A0_AUTOINC];
      st_next.aux0[DFA_A0_CLRDMA] = bus_i.wdata[DFA_A0_CLRDMA];
      st_next.aux0[DFA_A0_BRSRC] = bus_i.wdata[DFA_A0_BRSRC];
      st_next.aux0[DFA_A0_TIDXEN] = bus_i.wdata[DFA_A0_TIDXEN];
      st_next.aux0[DFA_A0_SPLIT] = bus_i.wdata[DFA_A0_SPLIT];
      // Firmware alone sets power-down, and only while not locked out.
      if (!bus_i.wdata[DFA_A0_PWRDN] || !st_reg.pd_lock) begin
        st_next.aux0[DFA_A0_PWRDN] = bus_i.wdata[DFA_A0_PWRDN];
      end
    end
    // Register 1 keeps reserved bits at zero.
    if (wr_hit(bus_i, DFA_AUX1_OFFSET)) begin
      st_next.aux1 = {bus_i.wdata[7:3], 3'b000};
    end
    // Setting then clearing the control emits one clear pulse on the falling write.
    st_next.dma_clr = st_reg.aux0[DFA_A0_CLRDMA] && !st_next.aux0[DFA_A0_CLRDMA];
    // Writing 73H releases the power-down lockout.
    if (wr_hit(bus_i, DFA_HOST_ACK_OFFSET)) begin
      st_next.pd_lock = 1'b0;
    end
    // A host command clears power-down and locks it out.
    if (host_cmd_i) begin
      st_next.aux0[DFA_A0_PWRDN] = 1'b0;
      st_next.pd_lock = 1'b1;
    end
    // Buffer data port accesses advance a pointer when enabled.
    if (access && bus_i.addr == DFA_BUF_DATA_OFFSET && st_reg.aux0[DFA_A0_AUTOINC]) begin
      st_next.wp_inc = read_op_select_i;
      st_next.rp_inc = !read_op_select_i;
    end
    // ECC status clears on formatter reset, new calculation or a 79H write.
    if ((wr_hit(bus_i, DFA_FMT_CTRL_OFFSET) && bus_i.wdata[DFA_FMT_RESET_BIT])
        || ecc_start_i || wr_hit(bus_i, DFA_FMT_STAT_OFFSET)) begin
      st_next.aux0[DFA_A0_ECCERR] = 1'b0;
    end
    // A detected error wins over a simultaneous clear.
    if (ecc_error_i) begin
      st_next.aux0[DFA_A0_ECCERR] = 1'b1;
      st_next.ecc_id = id_field_i;
    end
    // Arming word observed while detection is enabled.
    if (st_next.aux0[DFA_A0_TIDXEN] && seq_exec_i && !seq_i.read_gate && !seq_i.xfer
        && seq_i.count[DFA_CNT_ARM_BIT]) begin
      st_next.armed = 1'b1;
      st_next.idx_cnt = 2'h0;
      st_next.aux0[DFA_A0_TWOIDX] = 1'b0;
    end else if (st_reg.armed) begin
      if (fmt_buf_xfer_i) begin
        st_next.armed = 1'b0;
        st_next.idx_cnt = 2'h0;
      end else if (index_edge_i) begin
        if (st_reg.idx_cnt == 2'h1) begin
          st_next.aux0[DFA_A0_TWOIDX] = 1'b1;
          st_next.armed = 1'b0;
          st_next.idx_cnt = 2'h0;
        end else begin
          st_next.idx_cnt = st_reg.idx_cnt + 2'h1;
        end
      end
    end
    // Disabling detection disarms it and clears its status.
    if (!st_next.aux0[DFA_A0_TIDXEN]) begin
      st_next.armed = 1'b0;
      st_next.idx_cnt = 2'h0;
      st_next.aux0[DFA_A0_TWOIDX] = 1'b0;
    end
    // Busy is cleared by the host status read or final read sector.
    if (st_reg.aux1[DFA_A1_BUSYCLR]) begin
      if (xt_mode_i) begin
        st_next.busy_clr = status_read_i;
      end else begin
        st_next.busy_clr = last_read_sector_i && fifo_full_i && dma_req_i;
      end
    end
    // Host resets clear power-down and the clear-DMA control.
    if (hard_clear) begin
      st_next.aux0[DFA_A0_PWRDN] = 1'b0;
      st_next.aux0[DFA_A0_CLRDMA] = 1'b0;
      st_next.dma_clr = 1'b0;
      st_next.pd_lock = 1'b0;
    end
  end

  // Registers state; local reset clears all and sets maximum wait states.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.aux0 <= DFA_AUX0_RESET;
      st_reg.aux1 <= {DFA_WAIT_RESET, 6'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    unique case (bus_i.addr)
      DFA_AUX0_OFFSET: rdata_o = st_reg.aux0;
      DFA_AUX1_OFFSET: rdata_o = st_reg.aux1;
      default: rdata_o = 8'h00;
    endcase
  end

  // Branch address source selection.
  assign branch_addr_o = st_reg.aux0[DFA_A0_BRSRC] ? seq_i.data[4:0] : branch_reg_i[4:0];

  // Control bit 3 meaning depends on the split enable.
  assign split_field_o = st_reg.aux0[DFA_A0_SPLIT] && seq_i.ctrl_bit3;
  assign invalid_nrz_block_o = !st_reg.aux0[DFA_A0_SPLIT] && seq_i.ctrl_bit3
                               && media_read_enable_i;

  // The two-index status holds the sequencer stopped.
  assign force_stop_o = st_reg.aux0[DFA_A0_TWOIDX];

  // Sequencer word writes are only permitted while stopped.
  assign seq_write_ok_o = seq_stopped_i || st_reg.aux0[DFA_A0_TWOIDX];

  // Unused clocking runs unless power-down is set.
  assign clock_run_o = !st_reg.aux0[DFA_A0_PWRDN];

  // ECC generator preset polarity.
  assign ecc_preset_ones_o = !st_reg.aux1[DFA_A1_ECCPRE];

  assign write_address_pointer_inc_o = st_reg.wp_inc;
  assign read_address_pointer_inc_o = st_reg.rp_inc;
  assign clear_dma_enable_o = st_reg.dma_clr;
  assign busy_clear_o = st_reg.busy_clr;
  assign rd_ref_clk_o = filt_out;

  // Glitch filter on the read/reference clock input.
  dfa_glitch_filter u_filter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bypass_i(st_reg.aux1[DFA_A1_FILTDIS]),
    .sig_i(rd_ref_clk_i),
    .sig_o(filt_out)
  );

  // Local ready wait-state generator.
  dfa_wait_gen u_wait (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .access_i(access),
    .wait_sel_i(st_reg.aux1[DFA_A1_WAIT_LO +: 2]),
    .buf_tick_i(buffer_timing_clock_i),
    .ready_n_o(local_ready_n_o)
  );

endmodule : dfa_aux_control

// ---- dv/dfa_aux_control_monitor.sv ----
`timescale 1ns/1ps
// Port-level checker for the auxiliary control block.
module dfa_aux_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic host_bus_reset_i,
  input wire logic host_prog_reset_i,
  input wire logic host_cmd_i,
  input dfa_pkg::dfa_bus_t bus_i,
  input wire logic local_ready_n_o,
  input wire logic read_op_select_i,
  input wire logic write_address_pointer_inc_o,
  input wire logic read_address_pointer_inc_o,
  input wire logic clock_run_o,
  input wire logic ecc_preset_ones_o,
  input dfa_pkg::dfa_seq_t seq_i,
  input wire logic [7:0] branch_reg_i,
  input wire logic [4:0] branch_addr_o,
  input wire logic split_field_o,
  input wire logic invalid_nrz_block_o,
  input wire logic media_read_enable_i,
  input wire logic xt_mode_i,
  input wire logic status_read_i,
  input wire logic busy_clear_o,
  input wire logic force_stop_o
);
  import dfa_pkg::*;
  logic [7:0] a0_reg; // Shadow of control register 0, fed by bus writes.
  logic [7:0] a1_reg; // Shadow of control register 1.
  // Shadows follow bus writes, not the block.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a0_reg <= DFA_AUX0_RESET;
      a1_reg <= 8'hC0;
    end else if (bus_i.wr && bus_i.addr == DFA_AUX0_OFFSET) begin
      a0_reg <= bus_i.wdata;
    end else if (bus_i.wr && bus_i.addr == DFA_AUX1_OFFSET) begin
      a1_reg <= bus_i.wdata;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // A buffer data port access with auto-increment on.
  sequence s_buf;
    (bus_i.rd || bus_i.wr) && bus_i.addr == DFA_BUF_DATA_OFFSET && a0_reg[DFA_A0_AUTOINC];
  endsequence
  // Detection held off for two cycles running.
  sequence s_off_two;
    !a0_reg[DFA_A0_TIDXEN] [*2];
  endsequence
  chk_inc_write: assert property (s_buf ##0 read_op_select_i |=> write_address_pointer_inc_o)
    else $error("write pointer did not advance");
  chk_inc_read: assert property (s_buf ##0 !read_op_select_i |=> read_address_pointer_inc_o)
    else $error("read pointer did not advance");
  chk_branch_src: assert property (
    branch_addr_o == (a0_reg[DFA_A0_BRSRC] ? seq_i.data[4:0] : branch_reg_i[4:0]))
    else $error("branch address from wrong source");
  chk_split_mode: assert property (split_field_o == (a0_reg[DFA_A0_SPLIT] && seq_i.ctrl_bit3)
    && invalid_nrz_block_o == (!a0_reg[DFA_A0_SPLIT] && seq_i.ctrl_bit3 && media_read_enable_i))
    else $error("control bit 3 meaning wrong");
  chk_preset_pol: assert property (ecc_preset_ones_o == !a1_reg[DFA_A1_ECCPRE])
    else $error("preset polarity wrong");
  chk_pd_clear: assert property (host_bus_reset_i || host_prog_reset_i || host_cmd_i |=> clock_run_o)
    else $error("power-down not cleared");
  chk_ready_nowait: assert property (
    $rose(bus_i.rd || bus_i.wr) && a1_reg[7:6] == 2'h0 |-> !local_ready_n_o)
    else $error("ready delayed with no wait states");
  chk_stop_off: assert property (s_off_two |-> !force_stop_o)
    else $error("two-index status with detection off");
  chk_busy_xt: assert property (
    a1_reg[DFA_A1_BUSYCLR] && xt_mode_i && status_read_i |=> busy_clear_o)
    else $error("busy not cleared on status read");
endmodule : dfa_aux_monitor

bind dfa_aux_control dfa_aux_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .host_bus_reset_i(host_bus_reset_i),
  .host_prog_reset_i(host_prog_reset_i), .host_cmd_i(host_cmd_i), .bus_i(bus_i), .local_ready_n_o(local_ready_n_o),
  .read_op_select_i(read_op_select_i), .write_address_pointer_inc_o(write_address_pointer_inc_o),
  .read_address_pointer_inc_o(read_address_pointer_inc_o), .clock_run_o(clock_run_o),
  .ecc_preset_ones_o(ecc_preset_ones_o), .seq_i(seq_i), .branch_reg_i(branch_reg_i), .branch_addr_o(branch_addr_o),
  .split_field_o(split_field_o), .invalid_nrz_block_o(invalid_nrz_block_o), .xt_mode_i(xt_mode_i),
  .status_read_i(status_read_i), .busy_clear_o(busy_clear_o), .force_stop_o(force_stop_o),
  .media_read_enable_i(media_read_enable_i));

// ---- dv/dfa_mcu_model.sv ----
`timescale 1ns/1ps
// Local microcontroller: one register access at a time, held until ready.
module dfa_mcu_model (
  input wire logic clk_i,
  input wire logic local_ready_n_i,
  input wire logic [7:0] rdata_i,
  output dfa_pkg::dfa_bus_t bus_o
);
  import dfa_pkg::*;
  // Bus idle at time zero.
  initial begin
    bus_o = '{rd: 1'b0, wr: 1'b0, addr: 8'h00, wdata: 8'h00};
  end
  // One access; a released bus shows inverted values.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r, output int ok);
    int n;
    n = 0;
    @(posedge clk_i);
    bus_o <= '{rd: !wr, wr: wr, addr: a, wdata: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (local_ready_n_i !== 1'b0 && n < 64);
    r = rdata_i;
    ok = int'(n < 64);
    bus_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
endmodule : dfa_mcu_model

// ---- dv/dfa_aux_control_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the auxiliary control block.
module dfa_aux_control_tb;
  import dfa_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] ev = 10'h000; // Event pulses into the block, one bit each.
  logic tick = 1'b0, read_op_select = 1'b0, xt = 1'b0, rrc = 1'b0;
  dfa_seq_t seq = '0;
  logic [7:0] breg = 8'h00;
  dfa_bus_t bus;
  logic [7:0] rdata;
  logic [4:0] baddr;
  logic rdy_n, winc, rinc, crun, pre, fstop, split, nrz, wok, cdma, bclr, rrc_o;
  int n_errors = 0, compares = 0, cycles = 0, ticks = 0;
  int cnt [4] = '{0, 0, 0, 0}; // Pulse counts: write inc, read inc, clear DMA, busy clear.
  dfa_aux_control DUT (.clk_i(clk_i), .rst_i(rst_i), .host_bus_reset_i(ev[0]), .host_prog_reset_i(ev[1]),
    .host_cmd_i(ev[2]), .bus_i(bus), .rdata_o(rdata), .local_ready_n_o(rdy_n), .buffer_timing_clock_i(tick),
    .read_op_select_i(read_op_select), .write_address_pointer_inc_o(winc), .read_address_pointer_inc_o(rinc),
    .clock_run_o(crun), .ecc_error_i(ev[3]), .ecc_start_i(ev[4]), .id_field_i(1'b0), .ecc_preset_ones_o(pre),
    .index_edge_i(ev[5]), .fmt_buf_xfer_i(ev[6]), .seq_exec_i(ev[7]), .seq_stopped_i(1'b0), .seq_i(seq),
    .branch_reg_i(breg), .branch_addr_o(baddr), .force_stop_o(fstop), .split_field_o(split),
    .invalid_nrz_block_o(nrz), .seq_write_ok_o(wok), .clear_dma_enable_o(cdma), .xt_mode_i(xt),
    .status_read_i(ev[8]), .last_read_sector_i(ev[9]), .fifo_full_i(ev[9]), .dma_req_i(ev[9]),
    .busy_clear_o(bclr), .media_read_enable_i(seq.read_gate), .rd_ref_clk_i(rrc), .rd_ref_clk_o(rrc_o));
  dfa_mcu_model u_mcu (.clk_i(clk_i), .local_ready_n_i(rdy_n), .rdata_i(rdata), .bus_o(bus));
  always #4 clk_i = ~clk_i;
  // Buffer tick every second cycle, pulse counts and hang limit.
  always @(posedge clk_i) begin
    tick <= ~tick;
    cycles++;
    ticks += int'(tick === 1'b1);
    cnt[0] += int'(winc === 1'b1);
    cnt[1] += int'(rinc === 1'b1);
    cnt[2] += int'(cdma === 1'b1);
    cnt[3] += int'(bclr === 1'b1);
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic check1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask : check1
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    int ok;
    u_mcu.xfer(1'b1, a, d, r, ok);
    n_errors += 1 - ok;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] r);
    int ok;
    u_mcu.xfer(1'b0, a, 8'h00, r, ok);
    n_errors += 1 - ok;
  endtask : rreg
  // One-cycle pulse on an event input.
  task automatic pulse(input int b);
    @(posedge clk_i) ev[b] <= 1'b1;
    @(posedge clk_i) ev[b] <= 1'b0;
  endtask : pulse
  task automatic t_reset;
    logic [7:0] r;
    rreg(DFA_AUX0_OFFSET, r);
    check(r, DFA_AUX0_RESET);
    rreg(DFA_AUX1_OFFSET, r);
    check(r, 8'hC0);
    rreg(8'h50, r);
    check(r, 8'h00);
    check({6'h00, crun, pre}, 8'h03);
    $display("test reset done");
  endtask : t_reset
  task automatic t_regs;
    logic [7:0] r;
    wreg(DFA_AUX1_OFFSET, 8'hFF);
    rreg(DFA_AUX1_OFFSET, r);
    check(r, 8'hF8);
    wreg(DFA_AUX0_OFFSET, 8'h0C);
    rreg(DFA_AUX0_OFFSET, r);
    check(r, 8'h00);
    wreg(DFA_AUX1_OFFSET, 8'h00);
    $display("test registers done");
  endtask : t_regs
  task automatic t_wait;
    logic [7:0] r;
    int t0;
    for (int s = 3; s >= 0; s--) begin
      wreg(DFA_AUX1_OFFSET, {s[1:0], 6'h00});
      t0 = ticks;
      rreg(DFA_AUX0_OFFSET, r);
      check1(ticks - t0 >= s && ticks - t0 <= s + 2, 1'b1);
    end
    $display("test wait states done");
  endtask : t_wait
  task automatic t_auto;
    int w0, r0;
    for (int k = 0; k < 3; k++) begin
      wreg(DFA_AUX0_OFFSET, {7'h00, k < 2});
      @(posedge clk_i) read_op_select <= (k != 1);
      w0 = cnt[0];
      r0 = cnt[1];
      wreg(DFA_BUF_DATA_OFFSET, 8'h5A);
      repeat (3) @(negedge clk_i);
      check1(cnt[0] - w0 == 1, k == 0);
      check1(cnt[1] - r0 == 1, k == 1);
    end
    $display("test auto-increment done");
  endtask : t_auto
  task automatic t_power;
    wreg(DFA_AUX0_OFFSET, 8'h02);
    @(negedge clk_i) check1(crun, 1'b0);
    pulse(2);
    @(negedge clk_i) check1(crun, 1'b1);
    wreg(DFA_AUX0_OFFSET, 8'h02);
    @(negedge clk_i) check1(crun, 1'b1);
    wreg(DFA_HOST_ACK_OFFSET, 8'h00);
    wreg(DFA_AUX0_OFFSET, 8'h02);
    @(negedge clk_i) check1(crun, 1'b0);
    pulse(0);
    @(negedge clk_i) check1(crun, 1'b1);
    wreg(DFA_AUX0_OFFSET, 8'h02);
    pulse(1);
    @(negedge clk_i) check1(crun, 1'b1);
    $display("test power-down done");
  endtask : t_power
  task automatic t_ecc;
    logic [7:0] r;
    for (int k = 0; k < 3; k++) begin
      pulse(3);
      rreg(DFA_AUX0_OFFSET, r);
      check1(r[DFA_A0_ECCERR], 1'b1);
      case (k)
        0: wreg(DFA_FMT_STAT_OFFSET, 8'h00);
        1: pulse(4);
        default: wreg(DFA_FMT_CTRL_OFFSET, 8'h20);
      endcase
      rreg(DFA_AUX0_OFFSET, r);
      check1(r[DFA_A0_ECCERR], 1'b0);
    end
    $display("test ecc status done");
  endtask : t_ecc
  task automatic t_dma;
    logic [7:0] r;
    int c0;
    c0 = cnt[2];
    wreg(DFA_AUX0_OFFSET, 8'h10);
    rreg(DFA_AUX0_OFFSET, r);
    check1(r[DFA_A0_CLRDMA], 1'b1);
    wreg(DFA_AUX0_OFFSET, 8'h00);
    repeat (3) @(negedge clk_i);
    check1(cnt[2] - c0 == 1, 1'b1);
    $display("test clear dma done");
  endtask : t_dma
  task automatic t_tidx;
    logic [7:0] r;
    wreg(DFA_AUX0_OFFSET, 8'h40);
    @(posedge clk_i) seq <= '{read_gate: 1'b0, xfer: 1'b0, count: 8'h20, data: 8'h00, ctrl_bit3: 1'b0};
    pulse(7);
    pulse(5);
    @(negedge clk_i) check1(fstop, 1'b0);
    pulse(5);
    repeat (2) @(negedge clk_i);
    check1(fstop, 1'b1);
    check1(wok, 1'b1);
    rreg(DFA_AUX0_OFFSET, r);
    check1(r[DFA_A0_TWOIDX], 1'b1);
    pulse(7);
    repeat (2) @(negedge clk_i);
    check1(fstop, 1'b0);
    pulse(5);
    pulse(6);
    pulse(5);
    repeat (2) @(negedge clk_i);
    check1(fstop, 1'b0);
    pulse(7);
    pulse(5);
    pulse(5);
    wreg(DFA_AUX0_OFFSET, 8'h00);
    @(negedge clk_i) check1(fstop, 1'b0);
    $display("test two index done");
  endtask : t_tidx
  task automatic t_branch;
    @(posedge clk_i) seq <= '{read_gate: 1'b1, xfer: 1'b0, count: 8'h00, data: 8'hF3, ctrl_bit3: 1'b1};
    breg <= 8'h2C;
    for (int k = 0; k < 2; k++) begin
      wreg(DFA_AUX0_OFFSET, k ? 8'hA0 : 8'h00);
      @(negedge clk_i) check({3'h0, baddr}, k ? 8'h13 : 8'h0C);
      check1(split, k == 1);
      check1(nrz, k == 0);
      check1(wok, 1'b0);
    end
    $display("test branch and split done");
  endtask : t_branch
  task automatic t_aux1;
    int c0;
    wreg(DFA_AUX1_OFFSET, 8'h38);
    @(posedge clk_i) xt <= 1'b1;
    rrc <= 1'b1;
    @(negedge clk_i) check1(pre, 1'b0);
    check1(rrc_o, 1'b1);
    c0 = cnt[3];
    pulse(8);
    @(posedge clk_i) xt <= 1'b0;
    pulse(9);
    repeat (3) @(negedge clk_i);
    check1(cnt[3] - c0 == 2, 1'b1);
    wreg(DFA_AUX1_OFFSET, 8'h00);
    @(posedge clk_i) rrc <= 1'b0;
    repeat (6) @(posedge clk_i);
    rrc <= 1'b1;
    @(posedge clk_i) rrc <= 1'b0;
    repeat (5) @(negedge clk_i) check1(rrc_o, 1'b0);
    check1(pre, 1'b1);
    $display("test control register one done");
  endtask : t_aux1
  // Main sequence, with a second reset after the last test.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_regs();
    t_wait();
    t_auto();
    t_power();
    t_ecc();
    t_dma();
    t_tidx();
    t_branch();
    t_aux1();
    pulse(3);
    @(posedge clk_i) rst_i <= 1'b1;
    @(posedge clk_i) rst_i <= 1'b0;
    t_reset();
    end_sim();
  end
endmodule : dfa_aux_control_tb
